/* design/vapc_top.sv */
// Summary of operation
// RULE1: Clamp controller request to zero..hundred percent.
// RULE2: Invalid request code drives to safety position.
// RULE3: End targets run 130 percent runtime, interruptible.
// RULE4: Restart safety synchronisation cannot be interrupted, except by going offline.
// RULE5: Manual override beats controller, same clamping.
// RULE6: Override off resumes latest controller request.
// RULE7: Forward action: 0 extends, blink 4/1.
// RULE8: Inverted action: 0 retracts, blink 1/4.
// RULE9: Heartbeat expiry moves to safety position.
// RULE10: Window zero disables, up to 6553 seconds.
// RULE11: Heartbeat starts after first controller request.
// RULE12: Heartbeat expiry cancels manual override.
// RULE13: Halt option stops; first value adopts position.
// RULE14: Switch state follows contact and polarity.
// RULE15: Switch invalid for three seconds after restart.
// RULE16: Automatic runtime follows mains frequency.
// RULE17: Manual runtime rejects 0 and 6553.5.
// RULE18: Service message pulse after every restart.
// RULE19: Wink blinks indicator ten times.
// RULE20: Offline stops motor, outputs invalid, indicator off.
// RULE21: Online transition performs full restart.
// RULE22: Feedback from runtime model, invalid if unknown.
// RULE23: Target priority: safety, override, controller.
`timescale 1ns/1ns
`default_nettype none
module vapc_top
	import vapc_pkg::*;
#(
	parameter int MS_DIV = TICK_MS_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic signed [POS_W-1:0] requested_position_in,
	input wire logic requested_position_valid,
	input wire logic manual_enable,
	input wire logic signed [POS_W-1:0] manual_position_in,
	input wire logic manual_position_valid,
	input wire logic action_direction_cfg,
	input wire logic [15:0] heartbeat_window_cfg,
	input wire logic [1:0] safety_position_cfg,
	input wire logic [1:0] input_polarity_cfg,
	input wire logic input_contact,
	input wire logic runtime_manual_cfg,
	input wire logic [15:0] motor_runtime_cfg,
	input wire logic mains_60hz,
	input wire logic go_offline,
	input wire logic go_online,
	input wire logic wink,
	output logic [POS_W-1:0] position_feedback_out,
	output logic [1:0] input_switch_state,
	output logic motor_extend,
	output logic motor_retract,
	output logic status_led,
	output logic service_msg
);
	////////////////////////////////////////////////////////////////////////
	logic ms;
	vapc_tick #(.DIV(MS_DIV)) u_tick (
		.clk(clk),
		.reset(reset),
		.tick(ms)
	);

	vapc_state_e st, next_st;
	logic [9:0] ms_cnt, next_ms_cnt;
	logic sec;
	logic [15:0] hb_s, next_hb_s;
	// The window runs from the last request, not from the free second tick.
	logic [9:0] hb_ms, next_hb_ms;
	logic hb_armed, next_hb_armed;
	logic locked, next_locked;
	logic known, next_known;
	logic adopt, next_adopt;
	logic [31:0] pos_ms, next_pos_ms;
	logic [31:0] tgt_ms, next_tgt_ms;
	logic [31:0] sync_ms, next_sync_ms;
	logic [15:0] tgt_pos, next_tgt_pos;
	logic [15:0] last_req, next_last_req;
	logic safe_req, next_safe_req;
	logic [2:0] init_s, next_init_s;
	logic [4:0] wink_n, next_wink_n;
	logic [2:0] blink_s, next_blink_s;
	logic restart_pend, next_restart_pend;
	logic [15:0] pos_fb, next_pos_fb;
	logic [1:0] sw, next_sw;
	logic ext, next_ext, ret, next_ret, led, next_led, svc, next_svc;

	function automatic logic [15:0] clamp(input logic signed [15:0] v);
		if (v < 0)
			return 16'h0000;
		else if (v > $signed(POS_FULL))
			return POS_FULL;
		else
			return v;
	endfunction

	logic [31:0] run_ms;
	logic [31:0] full_ms;
	logic [15:0] hb_win;
	logic hb_on;
	always_comb begin
		// Runtime in 0.1 s units; out-of-range manual entries fall back.
		full_ms = 32'(RT_DEFAULT_DS) * 32'd100;
		if (mains_60hz)
			full_ms = (full_ms * 32'd5) / 32'd6; // [RULE16]
		run_ms = full_ms;
		if (runtime_manual_cfg && motor_runtime_cfg != 16'h0 &&
				{1'b0, motor_runtime_cfg} != RT_BAD_HI)
			run_ms = 32'(motor_runtime_cfg) * 32'd100; // [RULE17]
		hb_win = heartbeat_window_cfg;
		hb_on = hb_win != 16'h0 && hb_win <= HB_MAX_S; // [RULE10]
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [15:0] want;
		logic is_new;
		logic to_safety;
		want = tgt_pos;
		is_new = 1'b0;
		next_st = st;
		next_ms_cnt = ms_cnt;
		sec = 1'b0;
		next_hb_s = hb_s;
		next_hb_ms = hb_ms;
		next_hb_armed = hb_armed;
		next_locked = locked;
		next_known = known;
		next_adopt = adopt;
		next_pos_ms = pos_ms;
		next_tgt_ms = tgt_ms;
		next_sync_ms = sync_ms;
		next_tgt_pos = tgt_pos;
		next_last_req = last_req;
		next_safe_req = safe_req;
		next_init_s = init_s;
		next_wink_n = wink_n;
		next_blink_s = blink_s;
		next_restart_pend = 1'b0;
		next_svc = 1'b0;
		to_safety = 1'b0;
		if (ms) begin
			next_ms_cnt = ms_cnt + 10'h1;
			if (ms_cnt == 10'd999) begin
				next_ms_cnt = 10'h0;
				sec = 1'b1;
			end
		end
		if (requested_position_valid) begin
			next_hb_armed = 1'b1; // [RULE11]
			next_hb_s = 16'h0;
			next_hb_ms = 10'h0;
			if (requested_position_in == $signed(POS_INVALID))
				next_safe_req = 1'b1; // [RULE2]
			else begin
				next_safe_req = 1'b0;
				next_last_req = clamp(requested_position_in); // [RULE1]
			end
			if (!manual_enable)
				is_new = 1'b1;
		end else if (ms && hb_armed && hb_on) begin
			next_hb_ms = hb_ms + 10'h1;
			if (hb_ms == 10'd999) begin
				next_hb_ms = 10'h0;
				next_hb_s = hb_s + 16'h1;
				if (hb_s + 16'h1 >= hb_win) begin
					next_hb_armed = 1'b0;
					to_safety = 1'b1; // [RULE9] [RULE12]
				end
			end
		end
		if (manual_enable && manual_position_valid && !to_safety) begin
			want = clamp(manual_position_in); // [RULE5]
			is_new = 1'b1;
		end else if (!manual_enable && requested_position_valid) begin
			want = next_safe_req ? tgt_pos : next_last_req; // [RULE23]
			if (next_safe_req)
				to_safety = 1'b1;
		end
		// Going back from override re-targets the controller request.
		if (!manual_enable && tgt_pos != last_req && hb_armed &&
				!safe_req && !requested_position_valid && !locked) begin
			want = last_req; // [RULE6]
			is_new = 1'b1;
		end
		if (to_safety) begin
			is_new = 1'b1;
			want = (safety_position_cfg == SAFE_OPEN) ? POS_FULL :
				16'h0000;
		end
		if (sec) begin
			if (init_s != 3'h0)
				next_init_s = init_s - 3'h1;
			next_blink_s = (blink_s == 3'd4) ? 3'h0 : blink_s + 3'h1;
			if (wink_n != 5'h0)
				next_wink_n = wink_n - 5'h1;
		end
		if (wink)
			next_wink_n = 5'(2 * WINK_COUNT); // [RULE19]
		if (is_new && !locked && st != VAPC_OFFLINE) begin
			if (to_safety && safety_position_cfg == SAFE_STOP) begin
				next_st = VAPC_HALT; // [RULE13]
				next_tgt_ms = pos_ms;
			end else if (adopt) begin
				next_adopt = 1'b0; // [RULE13]
				next_known = 1'b1;
				next_tgt_pos = want;
				next_pos_ms = 32'((64'(want) * 64'(run_ms)) / 64'(POS_FULL));
				next_tgt_ms = next_pos_ms;
				next_st = VAPC_IDLE;
			end else begin
				next_tgt_pos = want;
				next_tgt_ms = 32'((64'(want) * 64'(run_ms)) / 64'(POS_FULL));
				if (want == 16'h0 || want == POS_FULL) begin
					next_st = VAPC_SYNC; // [RULE3]
					next_sync_ms = 32'((64'(run_ms) * SYNC_PCT) / 100);
				end else
					next_st = VAPC_MOVE;
			end
		end else if (ms) begin
			case (st)
				VAPC_MOVE: begin
					if (pos_ms < tgt_ms)
						next_pos_ms = pos_ms + 32'h1;
					else if (pos_ms > tgt_ms)
						next_pos_ms = pos_ms - 32'h1;
					else
						next_st = VAPC_IDLE;
				end
				VAPC_SYNC: begin
					if (tgt_pos == 16'h0 && pos_ms != 32'h0)
						next_pos_ms = pos_ms - 32'h1;
					if (tgt_pos != 16'h0 && pos_ms < run_ms)
						next_pos_ms = pos_ms + 32'h1;
					if (sync_ms <= 32'h1) begin
						next_st = VAPC_IDLE;
						next_locked = 1'b0; // [RULE4]
						next_known = 1'b1;
						next_pos_ms = tgt_ms;
					end else
						next_sync_ms = sync_ms - 32'h1;
				end
				default: begin
				end
			endcase
		end
		if (go_offline) begin
			next_st = VAPC_OFFLINE; // [RULE20]
			next_known = 1'b0;
		end
		if (go_online && st == VAPC_OFFLINE)
			next_restart_pend = 1'b1; // [RULE21]
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [2:0] on_s;
		logic dir_up;
		on_s = 3'h0;
		dir_up = 1'b0;
		next_sw = SW_INVALID;
		if (st != VAPC_OFFLINE && init_s == 3'h0) begin // [RULE15]
			if (input_polarity_cfg == POL_NO)
				next_sw = input_contact ? SW_ON : SW_OFF; // [RULE14]
			else if (input_polarity_cfg == POL_NC)
				next_sw = input_contact ? SW_OFF : SW_ON;
		end
		next_pos_fb = POS_INVALID; // [RULE22]
		if (known && st != VAPC_OFFLINE && run_ms != 32'h0)
			next_pos_fb = 16'((64'(pos_ms) * 64'(POS_FULL)) / 64'(run_ms));
		dir_up = (st == VAPC_MOVE && pos_ms < tgt_ms) ||
			(st == VAPC_SYNC && tgt_pos != 16'h0);
		// Forward action: higher position retracts the stem.
		next_ret = (st == VAPC_MOVE || st == VAPC_SYNC) &&
			(dir_up ^ action_direction_cfg); // [RULE7] [RULE8]
		next_ext = (st == VAPC_MOVE || st == VAPC_SYNC) &&
			!(dir_up ^ action_direction_cfg);
		if (st == VAPC_MOVE && pos_ms == tgt_ms) begin
			next_ret = 1'b0;
			next_ext = 1'b0;
		end
		on_s = action_direction_cfg ? 3'(BLINK_SHORT_S) : 3'(BLINK_LONG_S);
		next_led = blink_s < on_s; // [RULE7] [RULE8]
		if (wink_n != 5'h0)
			next_led = wink_n[0]; // [RULE19]
		if (st == VAPC_OFFLINE)
			next_led = 1'b0; // [RULE20]
	end

	always_ff @(posedge clk) begin
		if (reset || restart_pend) begin
			st <= VAPC_SYNC;
			ms_cnt <= 10'h0;
			hb_s <= 16'h0;
			hb_ms <= 10'h0;
			hb_armed <= 1'b0;
			locked <= 1'b1;
			known <= 1'b0;
			adopt <= 1'b0;
			pos_ms <= 32'h0;
			tgt_ms <= 32'h0;
			sync_ms <= 32'h0;
			tgt_pos <= 16'h0;
			last_req <= 16'h0;
			safe_req <= 1'b0;
			init_s <= 3'(INIT_S);
			wink_n <= 5'h0;
			blink_s <= 3'h0;
			restart_pend <= 1'b0;
			pos_fb <= POS_INVALID;
			sw <= SW_INVALID;
			ext <= 1'b0;
			ret <= 1'b0;
			led <= 1'b0;
			svc <= 1'b1; // [RULE18]
		end else begin
			st <= next_st;
			ms_cnt <= next_ms_cnt;
			hb_s <= next_hb_s;
			hb_ms <= next_hb_ms;
			hb_armed <= next_hb_armed;
			locked <= next_locked;
			known <= next_known;
			adopt <= next_adopt;
			pos_ms <= next_pos_ms;
			tgt_ms <= next_tgt_ms;
			sync_ms <= next_sync_ms;
			tgt_pos <= next_tgt_pos;
			last_req <= next_last_req;
			safe_req <= next_safe_req;
			init_s <= next_init_s;
			wink_n <= next_wink_n;
			blink_s <= next_blink_s;
			restart_pend <= next_restart_pend;
			pos_fb <= next_pos_fb;
			sw <= next_sw;
			ext <= next_ext;
			ret <= next_ret;
			led <= next_led;
			svc <= next_svc;
			// Restart safety run needs the runtime, taken on first cycle.
			if (st == VAPC_SYNC && locked && sync_ms == 32'h0) begin
				if (safety_position_cfg == SAFE_STOP) begin
					st <= VAPC_HALT; // [RULE13]
					locked <= 1'b0;
					adopt <= 1'b1;
				end else begin
					tgt_pos <= (safety_position_cfg == SAFE_OPEN) ?
						POS_FULL : 16'h0000; // [RULE4]
					tgt_ms <= (safety_position_cfg == SAFE_OPEN) ?
						run_ms : 32'h0;
					pos_ms <= (safety_position_cfg == SAFE_OPEN) ?
						32'h0 : run_ms;
					sync_ms <= 32'((64'(run_ms) * SYNC_PCT) / 100);
				end
			end
		end
	end

	assign position_feedback_out = pos_fb;
	assign input_switch_state = sw;
	assign motor_extend = ext;
	assign motor_retract = ret;
	assign status_led = led;
	assign service_msg = svc;

	////////////////////////////////////////////////////////////////////////
	a_offline_outputs: assert property (@(posedge clk) disable iff (reset)
		go_offline |=> ##1 (position_feedback_out == POS_INVALID &&
		input_switch_state == SW_INVALID && !status_led &&
		!motor_extend && !motor_retract))
		else $error("offline outputs not cleared"); // [RULE20]
	a_switch_init: assert property (@(posedge clk) disable iff (reset)
		init_s != 3'h0 |=> input_switch_state == SW_INVALID)
		else $error("switch valid during init"); // [RULE15]
	a_motor_excl: assert property (@(posedge clk) disable iff (reset)
		!(motor_extend && motor_retract))
		else $error("motor driven both ways"); // [RULE7]
	a_svc_pulse: assert property (@(posedge clk) disable iff (reset)
		service_msg |=> !service_msg)
		else $error("service message not a pulse"); // [RULE18]
	a_fb_range: assert property (@(posedge clk) disable iff (reset)
		position_feedback_out == POS_INVALID ||
		position_feedback_out <= POS_FULL)
		else $error("feedback out of range"); // [RULE22]
	a_req_clamp: assert property (@(posedge clk) disable iff (reset)
		last_req <= POS_FULL)
		else $error("request not clamped"); // [RULE1]
	a_lock_hold: assert property (@(posedge clk) disable iff (reset)
		locked && st == VAPC_SYNC && !go_offline |=> st == VAPC_SYNC ||
		!locked || st == VAPC_HALT)
		else $error("restart sync interrupted"); // [RULE4]
	a_unused_sw: assert property (@(posedge clk) disable iff (reset)
		input_polarity_cfg == POL_UNUSED ##1 input_polarity_cfg ==
		POL_UNUSED |-> input_switch_state == SW_INVALID)
		else $error("unused input not invalid"); // [RULE14]
endmodule
`default_nettype wire

/* design/vapc_pkg.sv */
package vapc_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int POS_W = 16;
	// Position in units of 0.005 %: 100 % is 20000, invalid is 32767.
	localparam logic [15:0] POS_FULL = 16'h4E20;
	localparam logic [15:0] POS_INVALID = 16'h7FFF;
	localparam int SYNC_PCT = 130;
	localparam int BLINK_LONG_S = 4;
	localparam int BLINK_SHORT_S = 1;
	localparam int INIT_S = 3;
	localparam int WINK_COUNT = 10;
	localparam logic [15:0] HB_MAX_S = 16'h1999;
	localparam logic [16:0] RT_BAD_HI = 17'h0FFFF;
	localparam logic [15:0] RT_DEFAULT_DS = 16'h0096;
	localparam int TICK_MS_CYC = CLK_HZ / 1000;
	localparam logic [1:0] SAFE_CLOSE = 2'h0;
	localparam logic [1:0] SAFE_OPEN = 2'h1;
	localparam logic [1:0] SAFE_STOP = 2'h2;
	localparam logic [1:0] SW_INVALID = 2'h0;
	localparam logic [1:0] SW_OFF = 2'h1;
	localparam logic [1:0] SW_ON = 2'h2;
	localparam logic [1:0] POL_NO = 2'h0;
	localparam logic [1:0] POL_NC = 2'h1;
	localparam logic [1:0] POL_UNUSED = 2'h2;
	typedef enum logic [2:0] {
		VAPC_IDLE = 3'b000,
		VAPC_MOVE = 3'b001,
		VAPC_SYNC = 3'b010,
		VAPC_HALT = 3'b011,
		VAPC_OFFLINE = 3'b100
	} vapc_state_e;
endpackage

/* design/vapc_tick.sv */
`timescale 1ns/1ns
`default_nettype none
module vapc_tick
	import vapc_pkg::*;
#(
	parameter int DIV = TICK_MS_CYC
) (
	input wire logic clk,
	input wire logic reset,
	output logic tick
);
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic next_tick;

	always_comb begin
		next_cnt = cnt + 32'h1;
		next_tick = 1'b0;
		if (cnt >= 32'(DIV - 1)) begin
			next_cnt = 32'h0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt <= 32'h0;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule
`default_nettype wire

/* testbench/vapc_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Remote controller: one position request per send strobe.
module vapc_ctrl_model
	import vapc_pkg::*;
(
	input wire logic clk,
	input wire logic send,
	input wire logic signed [POS_W-1:0] value,
	output logic signed [POS_W-1:0] position,
	output logic valid
);
	// Between messages the value lines carry junk, so a design that
	// reads them without the strobe picks up a wrong position.
	always_ff @(posedge clk) begin
		valid <= send;
		position <= send ? value : ~position;
	end
endmodule
`default_nettype wire

/* testbench/vapc_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
module vapc_top_test
	import vapc_pkg::*;
;
	logic clk = 0, reset = 1, req_send = 0, man_en = 0, man_vld = 0;
	logic signed [15:0] req_val = 0, man_val = 0, req_pos;
	logic req_vld, dir = 0, contact = 1, go_off = 0, go_on = 0;
	logic [15:0] hb_win = 0;
	logic [1:0] pol = POL_NO;
	logic [15:0] fb;
	logic [1:0] sw;
	logic ext, ret, led, svc;
	int bad_count = 0, comparisons = 0;
	initial forever #5 clk = ~clk;
	vapc_ctrl_model i_ctrl (.clk(clk), .send(req_send), .value(req_val),
		.position(req_pos), .valid(req_vld));
	// The ms tick is shortened so that one ms is ten clocks.
	vapc_top #(.MS_DIV(10)) i_dut (.clk(clk), .reset(reset),
		.requested_position_in(req_pos), .requested_position_valid(req_vld),
		.manual_enable(man_en), .manual_position_in(man_val),
		.manual_position_valid(man_vld), .action_direction_cfg(dir),
		.heartbeat_window_cfg(hb_win), .safety_position_cfg(SAFE_CLOSE),
		.input_polarity_cfg(pol), .input_contact(contact),
		.runtime_manual_cfg(1'b1), .motor_runtime_cfg(16'h0001),
		.mains_60hz(1'b0), .go_offline(go_off), .go_online(go_on),
		.wink(1'b0), .position_feedback_out(fb), .input_switch_state(sw),
		.motor_extend(ext), .motor_retract(ret), .status_led(led),
		.service_msg(svc));
////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic send_req(input logic signed [15:0] v);
		@(posedge clk);
		req_send <= 1'b1;
		req_val <= v;
		@(posedge clk);
		req_send <= 1'b0;
	endtask
	task automatic send_man(input logic signed [15:0] v);
		@(posedge clk);
		man_vld <= 1'b1;
		man_val <= v;
		@(posedge clk);
		man_vld <= 1'b0;
	endtask
	// Motion of 130 ms at most (1300 clocks) is about three times shorter than this bound.
	task automatic wait_idle();
		int n;
		n = 0;
		tick(3);
		#1;
		while ((ext !== 1'b0 || ret !== 1'b0) && n < 4000) begin
			tick(1);
			#1;
			n++;
		end
		if (n == 4000) begin
			bad_count++;
			$display("CHECK FAILED %0t motor never stopped", $time);
			end_of_test();
		end
	endtask
	task automatic count_svc(input int cycles);
		int n;
		n = 0;
		// The pulse may already stand when the count begins.
		repeat (cycles) begin
			#1;
			if (svc === 1'b1)
				n++;
			tick(1);
		end
		chk(16'(n), 16'h0001);
	endtask
////////////////////////////////////////////////////////////////////////////////
	task automatic t_restart();
		count_svc(4);
		chk(16'(sw), 16'(SW_INVALID));
		chk(16'({ext, ret}), 16'h0002);
		send_req(16'sh2710);
		tick(5);
		#1;
		chk(16'({ext, ret}), 16'h0002);
		wait_idle();
		chk(fb, 16'h0000);
		chk(16'(sw), 16'(SW_INVALID));
	endtask
	task automatic t_clamp();
		send_req(16'sh7530);
		tick(3);
		#1;
		chk(16'({ext, ret}), 16'h0001);
		wait_idle();
		chk(fb, POS_FULL);
		send_req(-16'sd500);
		tick(3);
		#1;
		chk(16'({ext, ret}), 16'h0002);
		wait_idle();
		chk(fb, 16'h0000);
	endtask
	task automatic t_manual();
		man_en <= 1'b1;
		send_man(16'sh2710);
		wait_idle();
		chk(fb, 16'h2710);
		send_req(16'sh0FA0);
		tick(5);
		#1;
		chk(16'({ext, ret}), 16'h0000);
		man_en <= 1'b0;
		wait_idle();
		chk(fb, 16'h0FA0);
	endtask
	task automatic t_invalid_dir();
		send_req(16'sh7FFF);
		wait_idle();
		chk(fb, 16'h0000);
		dir <= 1'b1;
		send_req(16'sh0000);
		tick(3);
		#1;
		chk(16'({ext, ret}), 16'h0001);
		wait_idle();
		chk(fb, 16'h0000);
		dir <= 1'b0;
	endtask
	task automatic t_heartbeat();
		hb_win <= 16'h0001;
		send_req(16'sh2710);
		wait_idle();
		man_en <= 1'b1;
		send_man(16'sh36B0);
		wait_idle();
		chk(fb, 16'h36B0);
		tick(9800);
		wait_idle();
		chk(fb, 16'h0000);
		man_en <= 1'b0;
		hb_win <= 16'h0000;
	endtask
	task automatic t_switch();
		logic [4:0] pc [5] = '{5'h06, 5'h01, 5'h0A, 5'h0D, 5'h10};
		tick(20000);
		foreach (pc[i]) begin
			@(posedge clk);
			pol <= pc[i][4:3];
			contact <= pc[i][2];
			tick(3);
			#1;
			chk(16'(sw), 16'(pc[i][1:0]));
		end
		pol <= POL_NO;
	endtask
	task automatic t_offline();
		send_req(16'sh4E20);
		send_req(16'sh0000);
		tick(5);
		go_off <= 1'b1;
		tick(1);
		go_off <= 1'b0;
		tick(3);
		#1;
		chk(16'({ext, ret, led}), 16'h0000);
		chk(fb, POS_INVALID);
		chk(16'(sw), 16'(SW_INVALID));
		tick(1);
		go_on <= 1'b1;
		tick(1);
		go_on <= 1'b0;
		count_svc(5);
		chk(16'({ext, ret}), 16'h0002);
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(10);
		reset <= 1'b0;
		t_restart();
		t_clamp();
		t_manual();
		t_invalid_dir();
		t_heartbeat();
		t_switch();
		t_offline();
		end_of_test();
	end
endmodule
`default_nettype wire
